// ===== design/serial_port_params.svh
// constants of the secondary serial port controller
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH

`define CLK_HZ                200000000
`define CLK_PERIOD_NS         5
`define MS_NS                 1000000
`define MS_CYCLES             (`MS_NS / `CLK_PERIOD_NS)

`define BAUD_300              300
`define BAUD_600              600
`define BAUD_900              900
`define BAUD_2400             2400
`define BAUD_4800             4800
`define BAUD_9600             9600
`define BAUD_19200            19200
`define BAUD_38400            38400

`define REMOTE_MASTER_STATION 8'h00
`define NET_MASTER_STATION    8'h01
`define NET_SLAVE_MIN         8'h01
`define NET_SLAVE_MAX         8'h5a
`define REMOTE_SLAVES         7
`define TABLE_WORDS           32
`define TABLE_LAST_USED       5'h1b
`define DATA_W                8
`define FIFO_DEPTH            16

`endif

// ===== design/serial_port_pkg.sv
// types of the secondary serial port controller
package serial_port_pkg;

	typedef enum logic {MODE_NET = 1'b0, MODE_REMOTE = 1'b1} mode_type;
	typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_EVEN = 2'b01, PAR_ODD = 2'b10} parity_type;
	typedef enum logic [1:0] {ECHO_RS232 = 2'b00, ECHO_4WIRE = 2'b01, ECHO_2WIRE = 2'b10} echo_type;
	typedef enum logic [2:0] {
		B300 = 3'b000, B600 = 3'b001, B900 = 3'b010, B2400 = 3'b011,
		B4800 = 3'b100, B9600 = 3'b101, B19200 = 3'b110, B38400 = 3'b111
	} baud_type;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000, TX_RTS_ON = 3'b001, TX_SEND = 3'b010,
		TX_RTS_OFF = 3'b011, TX_WAIT_RSP = 3'b100
	} tx_state_type;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b10, RX_STOP = 2'b11
	} rx_state_type;
	typedef enum logic [1:0] {SC_IDLE = 2'b00, SC_READ = 2'b01, SC_RUN = 2'b10} scan_state_type;

	typedef struct packed {
		mode_type   mode;
		logic [7:0] station;
		baud_type   baud;
		logic       two_stop;
		parity_type parity;
		echo_type   echo;
		logic [15:0] timeout_ms;
		logic [15:0] rts_on_ms;
		logic [15:0] rts_off_ms;
	} cfg_type;

	typedef struct packed {
		logic [7:0] data;
		logic       parity_err;
		logic       frame_err;
	} rx_char_type;

endpackage : serial_port_pkg

// ===== design/char_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module char_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             clk_sys_i,
	input  wire logic             nrst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             push, pop;

	always_comb
	begin
		push  = in_valid_i && in_ready_o;
		pop   = out_valid_o && out_ready_i;
		wr_d  = push ? wr_q + 1'b1 : wr_q;
		rd_d  = pop ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wr_q        <= '0;
			rd_q        <= '0;
			cnt_q       <= '0;
			in_ready_o  <= 1'b1;
			out_valid_o <= 1'b0;
		end
		else
		begin
			wr_q        <= wr_d;
			rd_q        <= rd_d;
			cnt_q       <= cnt_d;
			in_ready_o  <= cnt_d != (AW+1)'(DEPTH);
			out_valid_o <= cnt_d != '0;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (push)
			mem_q[wr_q] <= in_data_i;
	end

	assign out_data_o = mem_q[rd_q];

endmodule : char_fifo

// ===== design/serial_port_ctrl.sv
// secondary serial port: remote i/o master, network master/slave uart
`timescale 1ns/1ps
`include "serial_port_params.svh"

module serial_port_ctrl
	import serial_port_pkg::*;
#(
	parameter int MS_CYCLES = `MS_CYCLES
) (
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	input  wire cfg_type     cfg_i,
	input  wire logic        remote_setup_done_flag_i,
	output logic [4:0]       table_addr_o,
	input  wire logic [15:0] table_data_i,
	output logic [6:0]       slave_present_o,
	output logic             remote_link_run_o,
	input  wire logic        network_write_instruction_i,
	input  wire logic        network_read_instruction_i,
	input  wire logic [7:0]  target_slave_i,
	output logic             master_o,
	output logic             target_err_o,
	output logic             cfg_err_o,
	input  wire logic        tx_valid_i,
	output logic             tx_ready_o,
	input  wire logic [7:0]  tx_data_i,
	output logic             txd_o,
	output logic             rts_o,
	input  wire logic        rxd_i,
	output logic             rx_valid_o,
	output rx_char_type      rx_char_o,
	output logic             timeout_err_o
);
	//------------------------------------------------------------
	// bit timing
	//------------------------------------------------------------
	function automatic logic [19:0] bit_cycles(input baud_type b, input mode_type m);
		int rate;
		rate = `BAUD_38400;
		unique case (b)
			B300:   rate = `BAUD_300;
			B600:   rate = `BAUD_600;
			B900:   rate = `BAUD_900;
			B2400:  rate = `BAUD_2400;
			B4800:  rate = `BAUD_4800;
			B9600:  rate = `BAUD_9600;
			B19200: rate = `BAUD_19200;
			B38400: rate = `BAUD_38400;
		endcase
		if (m == MODE_REMOTE && b != B38400)
			rate = `BAUD_19200;
		return 20'(`CLK_HZ / rate);
	endfunction : bit_cycles

	logic [19:0] bit_len;
	logic        par_en;
	logic        par_odd;

	always_comb
	begin
		bit_len = bit_cycles(cfg_i.baud, cfg_i.mode);
		par_en  = cfg_i.parity != PAR_NONE;
		par_odd = cfg_i.parity == PAR_ODD;
	end

	//------------------------------------------------------------
	// role: remote table scan and network master
	//------------------------------------------------------------
	scan_state_type scan_q, scan_d;
	logic [4:0]     addr_q, addr_d;
	logic [6:0]     present_q, present_d;
	logic           master_d, terr_d, cerr_d, run_d;
	logic           remote_ok;
	logic           instr;

	always_comb
	begin
		scan_d    = scan_q;
		addr_d    = addr_q;
		present_d = present_q;
		remote_ok = cfg_i.mode == MODE_REMOTE && cfg_i.station == `REMOTE_MASTER_STATION;
		instr     = network_write_instruction_i || network_read_instruction_i;
		unique case (scan_q)
			SC_IDLE:
				if (remote_ok && remote_setup_done_flag_i)
				begin
					scan_d    = SC_READ;
					addr_d    = '0;
					present_d = '0;
				end
			SC_READ:
			begin
				if (table_data_i != 16'h0000)
					present_d[addr_q[4:2]] = 1'b1;
				addr_d = addr_q + 5'h01;
				if (addr_q == `TABLE_LAST_USED)
					scan_d = SC_RUN;
			end
			SC_RUN:
				if (!remote_ok || !remote_setup_done_flag_i)
					scan_d = SC_IDLE;
			default:
				scan_d = SC_IDLE;
		endcase
		run_d    = scan_d == SC_RUN;
		// slave unless station 01 in network mode has an instruction for a slave 01..5a right now
		master_d = cfg_i.mode == MODE_NET && cfg_i.station == `NET_MASTER_STATION && instr
			&& target_slave_i >= `NET_SLAVE_MIN && target_slave_i <= `NET_SLAVE_MAX;
		terr_d   = cfg_i.mode == MODE_NET && cfg_i.station == `NET_MASTER_STATION && instr
			&& (target_slave_i < `NET_SLAVE_MIN || target_slave_i > `NET_SLAVE_MAX);
		cerr_d   = cfg_i.mode == MODE_REMOTE
			&& (cfg_i.station != `REMOTE_MASTER_STATION
			|| (cfg_i.baud != B19200 && cfg_i.baud != B38400));
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			scan_q            <= SC_IDLE;
			addr_q            <= '0;
			present_q         <= '0;
			remote_link_run_o <= 1'b0;
			master_o          <= 1'b0;
			target_err_o      <= 1'b0;
			cfg_err_o         <= 1'b0;
		end
		else
		begin
			scan_q            <= scan_d;
			addr_q            <= addr_d;
			present_q         <= present_d;
			remote_link_run_o <= run_d;
			master_o          <= master_d;
			target_err_o      <= terr_d;
			cfg_err_o         <= cerr_d;
		end
	end

	assign table_addr_o    = addr_q;
	assign slave_present_o = present_q;

	//------------------------------------------------------------
	// transmit buffer
	//------------------------------------------------------------
	logic       fifo_valid;
	logic       fifo_pop;
	logic [7:0] fifo_data;

	char_fifo #(
		.WIDTH (`DATA_W),
		.DEPTH (`FIFO_DEPTH)
	) u_tx_fifo (
		.clk_sys_i   (clk_sys_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (tx_valid_i),
		.in_ready_o  (tx_ready_o),
		.in_data_i   (tx_data_i),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_data)
	);

	//------------------------------------------------------------
	// transmitter with rts timing and response timeout
	//------------------------------------------------------------
	tx_state_type tx_q, tx_d;
	logic [19:0]  tcnt_q, tcnt_d;
	logic [17:0]  pre_q, pre_d;
	logic [15:0]  ms_q, ms_d;
	logic [11:0]  sh_q, sh_d;
	logic [3:0]   nb_q, nb_d;
	logic         txd_d, rts_d, tmo_d, as_master;
	logic         rx_started;
	logic         ms_tick;
	logic         may_send;

	always_comb
	begin
		tx_d      = tx_q;
		tcnt_d    = tcnt_q;
		sh_d      = sh_q;
		nb_d      = nb_q;
		txd_d     = txd_o;
		rts_d     = rts_o;
		tmo_d     = 1'b0;
		fifo_pop  = 1'b0;
		as_master = master_o || remote_link_run_o;
		may_send  = cfg_i.mode == MODE_REMOTE ? remote_link_run_o : 1'b1;
		ms_tick   = pre_q == 18'(MS_CYCLES - 1);
		pre_d     = ms_tick ? '0 : pre_q + 18'h00001;
		ms_d      = ms_tick ? ms_q + 16'h0001 : ms_q;
		unique case (tx_q)
			TX_IDLE:
			begin
				pre_d = '0;
				ms_d  = '0;
				if (fifo_valid && may_send)
				begin
					tx_d  = TX_RTS_ON;
					rts_d = 1'b1;
				end
			end
			TX_RTS_ON:
				if (ms_q >= cfg_i.rts_on_ms && fifo_valid)
				begin
					tx_d     = TX_SEND;
					fifo_pop = 1'b1;
					tcnt_d   = '0;
					nb_d     = 4'd10 + {3'b000, par_en} + {3'b000, cfg_i.two_stop};
					sh_d     = par_en ? {2'b11, ^fifo_data ^ par_odd, fifo_data, 1'b0}
						: {3'b111, fifo_data, 1'b0};
				end
			TX_SEND:
			begin
				txd_d = sh_q[0];
				if (tcnt_q == bit_len - 20'h00001)
				begin
					tcnt_d = '0;
					sh_d   = {1'b1, sh_q[11:1]};
					nb_d   = nb_q - 4'h1;
					if (nb_q == 4'h1)
					begin
						if (fifo_valid)
						begin
							fifo_pop = 1'b1;
							nb_d     = 4'd10 + {3'b000, par_en} + {3'b000, cfg_i.two_stop};
							sh_d     = par_en ? {2'b11, ^fifo_data ^ par_odd, fifo_data, 1'b0}
								: {3'b111, fifo_data, 1'b0};
						end
						else
						begin
							tx_d  = TX_RTS_OFF;
							pre_d = '0;
							ms_d  = '0;
						end
					end
				end
				else
					tcnt_d = tcnt_q + 20'h00001;
			end
			TX_RTS_OFF:
			begin
				txd_d = 1'b1;
				if (ms_q >= cfg_i.rts_off_ms)
				begin
					rts_d = 1'b0;
					pre_d = '0;
					ms_d  = '0;
					tx_d  = as_master ? TX_WAIT_RSP : TX_IDLE;
				end
			end
			TX_WAIT_RSP:
				if (rx_started)
					tx_d = TX_IDLE;
				else if (ms_q >= cfg_i.timeout_ms)
				begin
					tmo_d = 1'b1;
					tx_d  = TX_IDLE;
				end
			default:
				tx_d = TX_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			tx_q          <= TX_IDLE;
			tcnt_q        <= '0;
			pre_q         <= '0;
			ms_q          <= '0;
			sh_q          <= '1;
			nb_q          <= '0;
			txd_o         <= 1'b1;
			rts_o         <= 1'b0;
			timeout_err_o <= 1'b0;
		end
		else
		begin
			tx_q          <= tx_d;
			tcnt_q        <= tcnt_d;
			pre_q         <= pre_d;
			ms_q          <= ms_d;
			sh_q          <= sh_d;
			nb_q          <= nb_d;
			txd_o         <= txd_d;
			rts_o         <= rts_d;
			timeout_err_o <= tmo_d;
		end
	end

	//------------------------------------------------------------
	// receiver with echo suppression
	//------------------------------------------------------------
	rx_state_type rx_q, rx_d;
	logic [19:0]  rcnt_q, rcnt_d;
	logic [8:0]   rsh_q, rsh_d;
	logic [3:0]   rnb_q, rnb_d;
	logic         rv_d, rx_block;
	rx_char_type  rc_d;
	logic [7:0]   rdata;
	logic         rpar;

	always_comb
	begin
		rx_d   = rx_q;
		rcnt_d = rcnt_q;
		rsh_d  = rsh_q;
		rnb_d  = rnb_q;
		rv_d   = 1'b0;
		rc_d   = rx_char_o;
		// shared pair: own line activity must not be taken as input
		rx_block = rts_o
			&& (cfg_i.mode == MODE_REMOTE || cfg_i.echo == ECHO_2WIRE);
		rdata = par_en ? rsh_q[7:0] : rsh_q[8:1];
		rpar  = rsh_q[8];
		rx_started = rx_q == RX_IDLE && !rxd_i && !rx_block;
		unique case (rx_q)
			RX_IDLE:
				if (rx_started)
				begin
					rx_d   = RX_START;
					rcnt_d = '0;
				end
			RX_START:
				if (rcnt_q == {1'b0, bit_len[19:1]})
				begin
					rcnt_d = '0;
					rnb_d  = 4'd8 + {3'b000, par_en};
					rx_d   = rxd_i ? RX_IDLE : RX_BITS;
				end
				else
					rcnt_d = rcnt_q + 20'h00001;
			RX_BITS:
				if (rcnt_q == bit_len - 20'h00001)
				begin
					rcnt_d = '0;
					rsh_d  = {rxd_i, rsh_q[8:1]};
					rnb_d  = rnb_q - 4'h1;
					if (rnb_q == 4'h1)
						rx_d = RX_STOP;
				end
				else
					rcnt_d = rcnt_q + 20'h00001;
			RX_STOP:
				if (rcnt_q == bit_len - 20'h00001)
				begin
					rcnt_d          = '0;
					rx_d            = RX_IDLE;
					rv_d            = 1'b1;
					rc_d.data       = rdata;
					rc_d.parity_err = par_en && ((^rdata ^ rpar) != par_odd);
					rc_d.frame_err  = !rxd_i;
				end
				else
					rcnt_d = rcnt_q + 20'h00001;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rx_q       <= RX_IDLE;
			rcnt_q     <= '0;
			rsh_q      <= '0;
			rnb_q      <= '0;
			rx_valid_o <= 1'b0;
			rx_char_o  <= '0;
		end
		else
		begin
			rx_q       <= rx_d;
			rcnt_q     <= rcnt_d;
			rsh_q      <= rsh_d;
			rnb_q      <= rnb_d;
			rx_valid_o <= rv_d;
			rx_char_o  <= rc_d;
		end
	end

endmodule : serial_port_ctrl

// ===== verif/serial_port_ctrl_assertions.sv
// concurrent checks on the serial port controller ports
`timescale 1ns/1ps
module serial_port_ctrl_assertions
	import serial_port_pkg::*;
#(
	parameter int MS_CYCLES = 20
) (
	input wire logic       clk_sys_i,
	input wire logic       nrst_i,
	input wire cfg_type    cfg_i,
	input wire logic       remote_setup_done_flag_i,
	input wire logic       network_write_instruction_i,
	input wire logic       network_read_instruction_i,
	input wire logic [7:0] target_slave_i,
	input wire logic       master_o,
	input wire logic       target_err_o,
	input wire logic       cfg_err_o,
	input wire logic       remote_link_run_o,
	input wire logic       txd_o,
	input wire logic       rts_o,
	input wire logic       rx_valid_o,
	input wire logic       timeout_err_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	logic instr;
	logic net_master;
	assign instr = network_write_instruction_i | network_read_instruction_i;
	assign net_master = cfg_i.mode == MODE_NET && cfg_i.station == 8'h01 && instr;

	sequence s_flag_up;
		$rose(remote_setup_done_flag_i) && !remote_link_run_o;
	endsequence
	sequence s_idle8;
		txd_o [*8];
	endsequence

	property p_master_on;
		net_master && target_slave_i >= 8'h01 && target_slave_i <= 8'h5a |=> master_o;
	endproperty
	property p_master_only;
		!(net_master && target_slave_i >= 8'h01 && target_slave_i <= 8'h5a) |=> !master_o;
	endproperty
	property p_target_err;
		net_master && (target_slave_i == 8'h00 || target_slave_i > 8'h5a) |=> target_err_o;
	endproperty
	property p_cfg_err;
		cfg_i.mode == MODE_REMOTE && (cfg_i.station != 8'h00
			|| !(cfg_i.baud == B19200 || cfg_i.baud == B38400)) |=> cfg_err_o;
	endproperty
	property p_run_gate;
		$rose(remote_link_run_o) |-> $past(remote_setup_done_flag_i)
			&& $past(cfg_i.mode) == MODE_REMOTE;
	endproperty
	property p_scan_first;
		s_flag_up |=> !remote_link_run_o [*8];
	endproperty
	property p_tx_needs_rts;
		!txd_o |-> rts_o;
	endproperty
	property p_rts_on_delay;
		$rose(rts_o) && cfg_i.rts_on_ms != 16'h0000 && MS_CYCLES >= 8 |-> s_idle8;
	endproperty
	property p_rx_pulse;
		rx_valid_o |=> !rx_valid_o;
	endproperty
	property p_timeout_pulse;
		timeout_err_o |=> !timeout_err_o;
	endproperty

	a_master_on: assert property (p_master_on) else $error("master not entered");
	a_master_only: assert property (p_master_only) else $error("master unexpected");
	a_target_err: assert property (p_target_err) else $error("target error missing");
	a_cfg_err: assert property (p_cfg_err) else $error("config error missing");
	a_run_gate: assert property (p_run_gate) else $error("link ran without flag");
	a_scan_first: assert property (p_scan_first) else $error("link ran before scan");
	a_tx_needs_rts: assert property (p_tx_needs_rts) else $error("data without rts");
	a_rts_on_delay: assert property (p_rts_on_delay) else $error("rts delay short");
	a_rx_pulse: assert property (p_rx_pulse) else $error("rx valid too long");
	a_timeout_pulse: assert property (p_timeout_pulse) else $error("timeout too long");
endmodule : serial_port_ctrl_assertions

// ===== verif/serial_node_model.sv
// far-side node: sends one even-parity frame on the receive line
`timescale 1ns/1ps
module serial_node_model #(
	parameter int BIT = 5208
) (
	input  wire logic       clk_sys_i,
	input  wire logic       send_i,
	input  wire logic [7:0] byte_i,
	output logic            rxd_o
);
	logic [10:0] frame;
	initial rxd_o = 1'b1;
	always @(posedge clk_sys_i)
	begin
		if (send_i)
		begin
			frame = {1'b1, ^byte_i, byte_i, 1'b0};
			for (int i = 0; i < 11; i++)
			begin
				rxd_o <= frame[i];
				repeat (BIT) @(posedge clk_sys_i);
			end
			rxd_o <= 1'b1;
		end
	end
endmodule : serial_node_model

// ===== verif/serial_port_ctrl_tb.sv
// self-checking bench for the serial port controller
`timescale 1ns/1ps
module serial_port_ctrl_tb
	import serial_port_pkg::*;
;
	localparam int MSC = 20;
	localparam int BIT = 200000000 / 38400;
	logic        clk_sys_i, nrst_i, flag, wr, rd, tx_valid, send;
	logic        tx_ready, txd, rts, rx_valid, master, target_err, cfg_err, run, tmo;
	logic [7:0]  target, tx_data, rx_byte, d, tg [5];
	logic [4:0]  taddr;
	logic [6:0]  present;
	logic [15:0] tbl [32];
	logic        rxd;
	cfg_type     cfg;
	rx_char_type rx_char;
	logic [9:0]  exp_q [$];
	int          checks, miscompares, cycles, n, dummy;

	serial_port_ctrl #(.MS_CYCLES(MSC)) serial_port_ctrl_i (.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i), .cfg_i(cfg), .remote_setup_done_flag_i(flag),
		.table_addr_o(taddr), .table_data_i(tbl[taddr]), .slave_present_o(present),
		.remote_link_run_o(run), .network_write_instruction_i(wr),
		.network_read_instruction_i(rd), .target_slave_i(target), .master_o(master),
		.target_err_o(target_err), .cfg_err_o(cfg_err), .tx_valid_i(tx_valid),
		.tx_ready_o(tx_ready), .tx_data_i(tx_data), .txd_o(txd), .rts_o(rts),
		.rxd_i(rxd), .rx_valid_o(rx_valid), .rx_char_o(rx_char), .timeout_err_o(tmo));
	serial_node_model #(.BIT(BIT)) serial_node_model_i (.clk_sys_i(clk_sys_i),
		.send_i(send), .byte_i(rx_byte), .rxd_o(rxd));

	always #2.5 clk_sys_i = ~clk_sys_i;

	task automatic cmp(string name, logic [15:0] exp, logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp

	task automatic final_report();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	// received characters against the noted ones
	always @(posedge clk_sys_i)
	begin
		if (rx_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				cmp("rx_extra", 0, 1);
			else
				cmp("rx_char", exp_q.pop_front(), rx_char);
		end
	end

	always @(posedge clk_sys_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 70000)
		begin
			miscompares++;
			final_report();
		end
	end

	initial
	begin
		dummy = $urandom(8817);
		clk_sys_i = 0;
		nrst_i = 0;
		cfg = '0;
		flag = 0;
		wr = 0;
		rd = 0;
		target = 0;
		tx_valid = 0;
		tx_data = 0;
		send = 0;
		rx_byte = 0;
		foreach (tbl[i]) tbl[i] = 16'h0000;
		tg = '{8'h00, 8'h01, 8'h5a, 8'h5b, 8'(1 + $urandom % 90)};
		repeat (5) @(posedge clk_sys_i);
		nrst_i <= 1;
		@(posedge clk_sys_i);
		cmp("master", 0, master);
		cmp("rts", 0, rts);
		// ----------------------------------------
		// network master selection
		// ----------------------------------------
		cfg.station <= 8'h01;
		foreach (tg[i])
		begin
			wr <= i[0];
			rd <= !i[0];
			target <= tg[i];
			repeat (3) @(posedge clk_sys_i);
			cmp("master", tg[i] >= 1 && tg[i] <= 90, master);
			cmp("target_err", tg[i] == 0 || tg[i] > 90, target_err);
		end
		rd <= 0;
		repeat (3) @(posedge clk_sys_i);
		cmp("master", 0, master);
		cfg.station <= 8'h02;
		wr <= 1;
		repeat (3) @(posedge clk_sys_i);
		cmp("master", 0, master);
		// ----------------------------------------
		// remote link table scan
		// ----------------------------------------
		wr <= 0;
		cfg.mode <= MODE_REMOTE;
		cfg.station <= 8'h00;
		cfg.baud <= B38400;
		tbl[2] <= 16'(1 + $urandom % 16'hfffe);
		tbl[9] <= 16'h0010;
		tbl[28] <= 16'h0001;
		repeat (40) @(posedge clk_sys_i);
		cmp("run", 0, run);
		flag <= 1;
		n = 0;
		while (run !== 1'b1 && n < 40)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		cmp("run", 1, run);
		cmp("present", 7'h05, present);
		cmp("cfg_err", 0, cfg_err);
		for (int b = 0; b < 8; b++)
		begin
			cfg.baud <= baud_type'(b);
			repeat (3) @(posedge clk_sys_i);
			cmp("cfg_err", b < 6, cfg_err);
		end
		cfg.station <= 8'h01;
		repeat (3) @(posedge clk_sys_i);
		cmp("cfg_err", 1, cfg_err);
		flag <= 0;
		cfg.mode <= MODE_NET;
		// ----------------------------------------
		// fifo fill, then reset empties it
		// ----------------------------------------
		cfg.rts_on_ms <= 16'h0064;
		for (int i = 0; i < 17; i++)
		begin
			tx_valid <= 1;
			tx_data <= 8'($urandom);
			@(posedge clk_sys_i);
		end
		tx_valid <= 0;
		repeat (2) @(posedge clk_sys_i);
		cmp("tx_ready", 0, tx_ready);
		nrst_i <= 0;
		repeat (2) @(posedge clk_sys_i);
		nrst_i <= 1;
		@(posedge clk_sys_i);
		cmp("tx_ready", 1, tx_ready);
		cmp("txd", 1, txd);
		// ----------------------------------------
		// one framed character out, one in alongside
		// ----------------------------------------
		cfg.rts_on_ms <= 16'h0001;
		cfg.rts_off_ms <= 16'h0001;
		cfg.timeout_ms <= 16'h0001;
		cfg.parity <= PAR_EVEN;
		wr <= 1;
		target <= 8'h05;
		d = 8'($urandom);
		dummy = $urandom;
		exp_q.push_back({8'(dummy), 2'b00});
		@(posedge clk_sys_i);
		tx_valid <= 1;
		tx_data <= d;
		rx_byte <= 8'(dummy);
		send <= 1;
		@(posedge clk_sys_i);
		tx_valid <= 0;
		send <= 0;
		n = 0;
		while (txd === 1'b1 && n < 100)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		cmp("rts_on_delay", 1, n >= MSC && n <= 2 * MSC + 5);
		repeat (BIT / 2) @(posedge clk_sys_i);
		cmp("start", 0, txd);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT) @(posedge clk_sys_i);
			cmp("tx_bit", d[i], txd);
		end
		repeat (BIT) @(posedge clk_sys_i);
		cmp("parity", ^d, txd);
		repeat (BIT) @(posedge clk_sys_i);
		cmp("stop", 1, txd);
		// count from the end of the stop bit
		repeat (BIT / 2) @(posedge clk_sys_i);
		n = 0;
		while (rts === 1'b1 && n < 4000)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		cmp("rts_off_delay", 1, n >= MSC && n <= 2 * MSC);
		n = 0;
		while (tmo !== 1'b1 && n < 200)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		cmp("timeout", 1, n >= MSC - 2 && n <= 2 * MSC);
		n = 0;
		while (exp_q.size() > 0 && n < 12 * BIT)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		cmp("rx_done", 0, exp_q.size());
		final_report();
	end
endmodule : serial_port_ctrl_tb

bind serial_port_ctrl serial_port_ctrl_assertions #(.MS_CYCLES(MS_CYCLES)) chk_i (
	.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cfg_i(cfg_i),
	.remote_setup_done_flag_i(remote_setup_done_flag_i),
	.network_write_instruction_i(network_write_instruction_i),
	.network_read_instruction_i(network_read_instruction_i),
	.target_slave_i(target_slave_i), .master_o(master_o), .target_err_o(target_err_o),
	.cfg_err_o(cfg_err_o), .remote_link_run_o(remote_link_run_o), .txd_o(txd_o),
	.rts_o(rts_o), .rx_valid_o(rx_valid_o), .timeout_err_o(timeout_err_o));
